/* verilog/pmcs_pkg.sv */
// Constants and types shared by the power-mode clock sequencer.
// Assumes a single sys_clk domain; software fields arrive as plain ports.
// What this block does
// R1 - Four modes plus a separate hibernate state
// R2 - Full-on: PLL running, not bypassed, clocks on
// R3 - Power-up starts in full-on mode
// R4 - Active: PLL bypassed, clocks at input rate
// R5 - Multiplier written in active applied at full-on
// R6 - Active mode keeps L1 DMA available
// R7 - Software re-enables PLL before full-on or sleep; the code turns the PLL on in both regardless of pllEnable_r
// R8 - Sleep: core clock stopped, PLL and system on
// R9 - Sleep wakeup picks mode from bypass bit
// R10 - Sleep mode blocks system DMA to L1
// R11 - Deep sleep: PLL off, both clocks off
// R12 - Hibernate: PLL and both clocks off, core power removed
// R13 - Zero core voltage setting enters hibernate
// R14 - Individual clock gate per peripheral
// R15 - Deep sleep real-time-clock wake goes active
// R16 - Reset wake in deep sleep goes full-on
// R17 - Zero frequency field drives wake output low
// R18 - Hibernate wakeup starts full hardware reset
// R19 - Clock switching never produces runt pulses
package pmcs_pkg;
  localparam int MULT_W = 6;
  localparam int REGULATOR_FREQUENCY_FIELD_W = 2;
  localparam int VLEV_W = 4;
  localparam int PERIPH_N = 16;
  localparam logic [MULT_W-1:0] MULT_RST = 6'h0A;
  localparam logic [REGULATOR_FREQUENCY_FIELD_W-1:0] REGULATOR_FREQUENCY_FIELD_RST = 2'h3;
  localparam logic [REGULATOR_FREQUENCY_FIELD_W-1:0] REGULATOR_FREQUENCY_FIELD_SHUTDOWN = 2'h0;
  localparam logic [VLEV_W-1:0] VLEV_RST = 4'hB;
  localparam logic [VLEV_W-1:0] VLEV_ZERO = 4'h0;
  localparam logic [PERIPH_N-1:0] PERIPH_RST = 16'hFFFF;
  localparam logic PLL_EN_RST = 1'b1;
  localparam logic PLL_BYP_RST = 1'b0;
  // Quiet time around a bypass switch, in ns and in cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWITCH_GAP_NS = 40;
  localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 4;
  localparam int SYNC_N = 4;
  typedef enum logic [2:0] {
    MODE_FULL_ON,
    MODE_ACTIVE,
    MODE_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_HIBERNATE
  } pmcs_mode_e;
endpackage

/* verilog/pmcs_clk_if.sv */
// Carrier between the mode controller and its clock-switch sequencer.
// Assumes both ends sit on sys_clk.
`timescale 1ns/10ps
interface pmcs_clk_if;
  logic wantCore;
  logic wantSys;
  logic wantBypass;
  logic coreEn;
  logic sysEn;
  logic bypassSel;
  logic busy;
  modport ctrl (output wantCore, output wantSys, output wantBypass,
    input coreEn, input sysEn, input bypassSel, input busy);
  modport seq (input wantCore, input wantSys, input wantBypass,
    output coreEn, output sysEn, output bypassSel, output busy);
endinterface

/* verilog/pmcs_clk_seq.sv */
// Clock-switch sequencer: gates both clocks around a bypass change.
// Assumes downstream integrated clock gates sample the enables cleanly.
`timescale 1ns/10ps
module pmcs_clk_seq (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Controller side
  pmcs_clk_if.seq link
);
  typedef enum logic [1:0] {SQ_RUN, SQ_GATE, SQ_SWAP} pmcs_seq_e;
  pmcs_seq_e state_r;
  logic [pmcs_pkg::GAP_W-1:0] gap_r;
  logic coreEn_r;
  logic sysEn_r;
  logic bypass_r;
  wire needSwap = link.wantBypass != bypass_r;
  wire gapDone = gap_r == pmcs_pkg::GAP_W'(pmcs_pkg::SWITCH_GAP_CYC - 1);

  // Bypass mux only moves while both clocks are gated off
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_r <= SQ_RUN;
      gap_r <= '0;
      coreEn_r <= 1'b1;
      sysEn_r <= 1'b1;
      bypass_r <= pmcs_pkg::PLL_BYP_RST;
    end
    else
    begin
      case (state_r)
        SQ_RUN:
        begin
          gap_r <= '0;
          if (needSwap)
          begin
            coreEn_r <= 1'b0; // see R19
            sysEn_r <= 1'b0;
            state_r <= SQ_GATE;
          end
          else
          begin
            coreEn_r <= link.wantCore;
            sysEn_r <= link.wantSys;
          end
        end
        SQ_GATE:
        begin
          gap_r <= gapDone ? '0 : gap_r + 1'b1;
          if (gapDone)
          begin
            bypass_r <= link.wantBypass; // see R19
            state_r <= SQ_SWAP;
          end
        end
        SQ_SWAP:
        begin
          gap_r <= gapDone ? '0 : gap_r + 1'b1;
          if (gapDone)
            state_r <= SQ_RUN; // Enables return on the next RUN cycle
        end
        default:
          state_r <= SQ_RUN;
      endcase
    end
  end

  assign link.coreEn = coreEn_r;
  assign link.sysEn = sysEn_r;
  assign link.bypassSel = bypass_r;
  assign link.busy = state_r != SQ_RUN;
endmodule

/* verilog/pmcs_power_mode_clock_sequencer.sv */
// Operating-mode controller: PLL, core/system clock gates, core power.
// Assumes software fields come with one-cycle write strobes on sys_clk;
// wake inputs are asynchronous pins and are synchronised here.
`timescale 1ns/10ps
module pmcs_power_mode_clock_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // PLL control register write
  input wire logic pllCtlWr,
  input wire logic pllEnableIn,
  input wire logic pllBypassIn,
  input wire logic [pmcs_pkg::MULT_W-1:0] multiplierIn,
  // Regulator control register write
  input wire logic vrCtlWr,
  input wire logic [pmcs_pkg::REGULATOR_FREQUENCY_FIELD_W-1:0] regulatorFrequencyIn,
  input wire logic [pmcs_pkg::VLEV_W-1:0] coreVoltageIn,
  input wire logic rtcWakeEnable,
  input wire logic phyWakeEnable,
  // Mode requests from software
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  // Peripheral clock gates
  input wire logic periphGateWr,
  input wire logic [pmcs_pkg::PERIPH_N-1:0] periphGateIn,
  // Asynchronous wake pins
  input wire logic wakeupPin,
  input wire logic rtcWakePin,
  input wire logic resetWakePin,
  input wire logic phyWakePin,
  // Clock and power controls
  output logic pllOn,
  output logic pllBypassed,
  output logic coreClkEn,
  output logic sysClkEn,
  output logic corePowerOn,
  output logic [pmcs_pkg::PERIPH_N-1:0] periphClkEn,
  output logic [pmcs_pkg::MULT_W-1:0] appliedMultiplier,
  // Status and system signals
  output logic [2:0] modeState,
  output logic dmaL1Allowed,
  output logic externalWakeOut,
  output logic hwResetReq,
  output logic switchBusy
);
  pmcs_clk_if clkLink ();
  pmcs_pkg::pmcs_mode_e mode_r;
  pmcs_pkg::pmcs_mode_e mode_nxt;
  logic pllEnable_r;
  logic pllBypass_r;
  logic [pmcs_pkg::MULT_W-1:0] multPending_r;
  logic [pmcs_pkg::MULT_W-1:0] multApplied_r;
  logic [pmcs_pkg::REGULATOR_FREQUENCY_FIELD_W-1:0] regulator_frequency_field_r;
  logic [pmcs_pkg::PERIPH_N-1:0] periph_r;
  logic extWake_r;
  logic hwReset_r;
  logic pllOn_r;
  logic dma_r;
  logic power_r;
  logic [pmcs_pkg::SYNC_N-1:0] syncA_r;
  logic [pmcs_pkg::SYNC_N-1:0] syncB_r;

  // Two-flop synchronisers for the wake pins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
    end
    else
    begin
      syncA_r <= {phyWakePin, resetWakePin, rtcWakePin, wakeupPin};
      syncB_r <= syncA_r;
    end
  end

  // Named wake conditions
  wire wakeSync = syncB_r[0];
  wire rtcSync = syncB_r[1];
  wire rstSync = syncB_r[2];
  wire phySync = syncB_r[3];
  wire hibWake = rstSync | (rtcSync & rtcWakeEnable) | (phySync & phyWakeEnable);
  wire goHibernate = vrCtlWr && coreVoltageIn == pmcs_pkg::VLEV_ZERO;
  wire bypassNow = pllCtlWr ? pllBypassIn : pllBypass_r;

  // Mode transitions; zero core voltage overrides any other request
  always_comb
  begin
    mode_nxt = mode_r;
    if (goHibernate && mode_r != pmcs_pkg::MODE_HIBERNATE)
      mode_nxt = pmcs_pkg::MODE_HIBERNATE; // see R13
    else
    begin
      case (mode_r)
        pmcs_pkg::MODE_FULL_ON,
        pmcs_pkg::MODE_ACTIVE:
        begin
          // Full-on and sleep turn the PLL on whether or not software re-enabled it
          if (deepSleepReq)
            mode_nxt = pmcs_pkg::MODE_DEEP_SLEEP;
          else if (sleepReq)
            mode_nxt = pmcs_pkg::MODE_SLEEP; // see R7
          else
            mode_nxt = bypassNow ? pmcs_pkg::MODE_ACTIVE : pmcs_pkg::MODE_FULL_ON;
        end
        pmcs_pkg::MODE_SLEEP:
          if (wakeSync)
            mode_nxt = pllBypass_r ? pmcs_pkg::MODE_ACTIVE : pmcs_pkg::MODE_FULL_ON; // see R9
        pmcs_pkg::MODE_DEEP_SLEEP:
          if (rstSync)
            mode_nxt = pmcs_pkg::MODE_FULL_ON; // see R16
          else if (rtcSync)
            mode_nxt = pmcs_pkg::MODE_ACTIVE; // see R15
        pmcs_pkg::MODE_HIBERNATE:
          if (hibWake)
            mode_nxt = pmcs_pkg::MODE_FULL_ON; // see R18
        default:
          mode_nxt = pmcs_pkg::MODE_FULL_ON;
      endcase
    end
  end

  // Mode register, power-up lands in full-on
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      mode_r <= pmcs_pkg::MODE_FULL_ON; // see R3
    else
      mode_r <= mode_nxt; // see R1
  end

  // PLL control fields; multiplier waits in a holding register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (mode_r == pmcs_pkg::MODE_HIBERNATE && hibWake))
    begin
      pllEnable_r <= pmcs_pkg::PLL_EN_RST;
      pllBypass_r <= pmcs_pkg::PLL_BYP_RST;
      multPending_r <= pmcs_pkg::MULT_RST;
    end
    else if (pllCtlWr)
    begin
      pllEnable_r <= pllEnableIn;
      pllBypass_r <= pllBypassIn;
      multPending_r <= multiplierIn;
    end
  end

  // Held multiplier only reaches the PLL on full-on
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      multApplied_r <= pmcs_pkg::MULT_RST;
    else if (mode_nxt == pmcs_pkg::MODE_FULL_ON)
      multApplied_r <= (pllCtlWr && mode_r == pmcs_pkg::MODE_FULL_ON) ? multiplierIn
        : multPending_r; // see R5
  end

  // Regulator field, wake pin and peripheral gates
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      regulator_frequency_field_r <= pmcs_pkg::REGULATOR_FREQUENCY_FIELD_RST;
      extWake_r <= 1'b1;
      periph_r <= pmcs_pkg::PERIPH_RST;
    end
    else
    begin
      if (vrCtlWr)
        regulator_frequency_field_r <= regulatorFrequencyIn;
      // A wake event raises the pin again and wins over a shutdown write
      if (mode_r == pmcs_pkg::MODE_HIBERNATE && hibWake)
        extWake_r <= 1'b1;
      else if (vrCtlWr && regulatorFrequencyIn == pmcs_pkg::REGULATOR_FREQUENCY_FIELD_SHUTDOWN)
        extWake_r <= 1'b0; // see R17
      if (mode_r == pmcs_pkg::MODE_HIBERNATE)
        periph_r <= pmcs_pkg::PERIPH_RST; // Lost with core power
      else if (periphGateWr)
        periph_r <= periphGateIn; // see R14
    end
  end

  // Per-mode settings derived from the next mode
  wire nxtSleepy = mode_nxt == pmcs_pkg::MODE_DEEP_SLEEP || mode_nxt == pmcs_pkg::MODE_HIBERNATE;
  wire nxtPll = !nxtSleepy && (pllEnable_r || mode_nxt != pmcs_pkg::MODE_ACTIVE);
  assign clkLink.wantCore = mode_nxt == pmcs_pkg::MODE_FULL_ON
    || mode_nxt == pmcs_pkg::MODE_ACTIVE; // see R8
  assign clkLink.wantSys = !nxtSleepy; // see R11
  assign clkLink.wantBypass = mode_nxt == pmcs_pkg::MODE_ACTIVE; // see R4

  // PLL power, DMA reach and core power flops
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pllOn_r <= 1'b1; // see R2
      dma_r <= 1'b1;
      power_r <= 1'b1;
      hwReset_r <= 1'b0;
    end
    else
    begin
      pllOn_r <= nxtPll; // see R11
      dma_r <= mode_nxt == pmcs_pkg::MODE_FULL_ON
        || mode_nxt == pmcs_pkg::MODE_ACTIVE; // see R6 see R10
      power_r <= mode_nxt != pmcs_pkg::MODE_HIBERNATE; // see R12
      hwReset_r <= mode_r == pmcs_pkg::MODE_HIBERNATE && hibWake; // see R18
    end
  end

  // Runt-free gating and bypass switching
  pmcs_clk_seq uSeq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .link(clkLink.seq)
  );

  // Output assignments, all from flops
  assign pllOn = pllOn_r;
  assign pllBypassed = clkLink.bypassSel;
  assign coreClkEn = clkLink.coreEn;
  assign sysClkEn = clkLink.sysEn;
  assign corePowerOn = power_r;
  assign periphClkEn = periph_r;
  assign appliedMultiplier = multApplied_r;
  assign modeState = mode_r;
  assign dmaL1Allowed = dma_r;
  assign externalWakeOut = extWake_r;
  assign hwResetReq = hwReset_r;
  assign switchBusy = clkLink.busy;
endmodule

/* verilog/unused_placeholder_none.sv */
`timescale 1ns/10ps

/* verification/pmcs_properties.sv */
// Checker on the top ports of the power-mode clock sequencer.
// Assumes one sys_clk domain and a synchronous active-high sys_rst.
`timescale 1ns/10ps
module pmcs_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Software writes
  input wire logic vrCtlWr,
  input wire logic [pmcs_pkg::REGULATOR_FREQUENCY_FIELD_W-1:0] regulatorFrequencyIn,
  input wire logic periphGateWr,
  input wire logic [pmcs_pkg::PERIPH_N-1:0] periphGateIn,
  // Controls and status
  input wire logic pllOn,
  input wire logic pllBypassed,
  input wire logic coreClkEn,
  input wire logic sysClkEn,
  input wire logic corePowerOn,
  input wire logic [pmcs_pkg::PERIPH_N-1:0] periphClkEn,
  input wire logic [pmcs_pkg::MULT_W-1:0] appliedMultiplier,
  input wire logic [2:0] modeState,
  input wire logic dmaL1Allowed,
  input wire logic externalWakeOut,
  input wire logic hwResetReq,
  input wire logic switchBusy
);
  logic [2:0] prevMode_r;
  logic prevBusy_r;
  wire logic settled;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Previous mode and busy, so a mode is judged only once its clocks settled
  always_ff @(posedge sys_clk)
  begin
    prevMode_r <= modeState;
    prevBusy_r <= switchBusy;
  end
  assign settled = modeState == prevMode_r && !switchBusy && !prevBusy_r;
  a_reset_full_on: assert property ($fell(sys_rst) |-> modeState == 3'h0 && pllOn
    && !pllBypassed && periphClkEn == 16'hFFFF && appliedMultiplier == 6'h0A) else $error("reset state");
  a_full_on_run: assert property (settled && modeState == 3'h0 |-> pllOn && !pllBypassed
    && coreClkEn && sysClkEn) else $error("full-on clocks");
  a_active_bypass: assert property (settled && modeState == 3'h1 |-> pllBypassed
    && coreClkEn && sysClkEn && dmaL1Allowed) else $error("active clocks");
  a_sleep_core_off: assert property (settled && modeState == 3'h2 |-> pllOn && !coreClkEn
    && sysClkEn && !dmaL1Allowed) else $error("sleep clocks");
  a_deep_all_off: assert property (settled && modeState == 3'h3 |-> !pllOn && !coreClkEn
    && !sysClkEn && corePowerOn) else $error("deep sleep clocks");
  a_hib_power_off: assert property (modeState == 3'h4 |-> !pllOn && !corePowerOn)
    else $error("hibernate power");
  a_hold_multiplier: assert property (modeState == 3'h1 && prevMode_r == 3'h1
    |-> $stable(appliedMultiplier)) else $error("multiplier moved in active");
  a_gate_write: assert property (periphGateWr |=> periphClkEn == $past(periphGateIn))
    else $error("peripheral gates");
  a_regulator_frequency_field_zero_low: assert property (vrCtlWr && regulatorFrequencyIn == 2'h0
    |=> !externalWakeOut) else $error("wake output not low");
  a_hib_wake_reset: assert property (hwResetReq |-> modeState == 3'h0
    && prevMode_r == 3'h4 ##1 !hwResetReq) else $error("hibernate wake reset");
  a_no_runt_switch: assert property ($changed(pllBypassed) |-> !coreClkEn && !sysClkEn
    && !$past(coreClkEn)) else $error("bypass switched with clocks on");
  c_sleep: cover property (modeState == 3'h2);
  c_deep: cover property (modeState == 3'h3);
  c_hib_wake: cover property (hwResetReq);
endmodule

bind pmcs_power_mode_clock_sequencer pmcs_properties u_chk (.sys_clk, .sys_rst, .vrCtlWr,
  .regulatorFrequencyIn, .periphGateWr, .periphGateIn, .pllOn, .pllBypassed, .coreClkEn,
  .sysClkEn, .corePowerOn, .periphClkEn, .appliedMultiplier, .modeState, .dmaL1Allowed,
  .externalWakeOut, .hwResetReq, .switchBusy);

/* verification/test_power_mode_clock_sequencer.sv */
// Self-checking bench for the power-mode clock sequencer.
// Drives every control port itself; no partner model.
`timescale 1ns/10ps
module test_power_mode_clock_sequencer;
  logic sys_clk = 1'b0, sys_rst = 1'b1, pllCtlWr = 1'b0, pllEnableIn = 1'b1, pllBypassIn = 1'b0;
  logic [5:0] multiplierIn = 6'h0A;
  logic vrCtlWr = 1'b0, rtcWakeEnable = 1'b1, phyWakeEnable = 1'b0, sleepReq = 1'b0;
  logic [1:0] regulatorFrequencyIn = 2'h3;
  logic [3:0] coreVoltageIn = 4'hB;
  logic deepSleepReq = 1'b0, periphGateWr = 1'b0, wakeupPin = 1'b0, rtcWakePin = 1'b0;
  logic resetWakePin = 1'b0, phyWakePin = 1'b0;
  logic [15:0] periphGateIn = 16'hFFFF;
  logic pllOn, pllBypassed, coreClkEn, sysClkEn, corePowerOn, dmaL1Allowed;
  logic externalWakeOut, hwResetReq, switchBusy;
  logic [15:0] periphClkEn;
  logic [5:0] appliedMultiplier;
  logic [2:0] modeState;
  int err_count = 0, num_checks = 0;
  pmcs_power_mode_clock_sequencer u_dut (.sys_clk, .sys_rst, .pllCtlWr, .pllEnableIn,
    .pllBypassIn, .multiplierIn, .vrCtlWr, .regulatorFrequencyIn, .coreVoltageIn,
    .rtcWakeEnable, .phyWakeEnable, .sleepReq, .deepSleepReq, .periphGateWr, .periphGateIn,
    .wakeupPin, .rtcWakePin, .resetWakePin, .phyWakePin, .pllOn, .pllBypassed, .coreClkEn,
    .sysClkEn, .corePowerOn, .periphClkEn, .appliedMultiplier, .modeState, .dmaL1Allowed,
    .externalWakeOut, .hwResetReq, .switchBusy);
  // Clock at 100 MHz
  always #5 sys_clk = ~sys_clk;
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Mode plus the seven control flags in one compare
  task chkSt(input logic [2:0] m, input logic [6:0] f);
    chk("state", {6'h0, modeState, pllOn, pllBypassed, coreClkEn, sysClkEn, corePowerOn,
      dmaL1Allowed, externalWakeOut}, {6'h0, m, f});
  endtask
  // Bounded wait for a mode with the switch idle, then let enables land
  task waitMode(input logic [2:0] m);
    int n;
    n = 0;
    #1;
    while (!(modeState === m && switchBusy === 1'b0) && n < 40)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 40)
    begin
      err_count++;
      results();
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task pll(input logic en, input logic byp, input logic [5:0] mul);
    @(posedge sys_clk);
    pllEnableIn <= en;
    pllBypassIn <= byp;
    multiplierIn <= mul;
    pllCtlWr <= 1'b1;
    @(posedge sys_clk);
    pllCtlWr <= 1'b0;
  endtask
  task req(input logic deep);
    @(posedge sys_clk);
    sleepReq <= !deep;
    deepSleepReq <= deep;
    @(posedge sys_clk);
    sleepReq <= 1'b0;
    deepSleepReq <= 1'b0;
  endtask
  task t_active;
    pll(1'b1, 1'b1, 6'h0A);
    pll(1'b1, 1'b1, 6'h15);
    waitMode(3'h1);
    chkSt(3'h1, 7'h7F);
    chk("mult held", {10'h0, appliedMultiplier}, 16'h000A);
    pll(1'b0, 1'b1, 6'h15);
    waitMode(3'h1);
    chk("pll off", {15'h0, pllOn}, 16'h0000);
    pll(1'b1, 1'b1, 6'h15); // PLL back on before leaving active
    pll(1'b1, 1'b0, 6'h15);
    waitMode(3'h0);
    chkSt(3'h0, 7'h5F);
    chk("mult", {10'h0, appliedMultiplier}, 16'h0015);
  endtask
  task t_sleep(input logic byp);
    req(1'b0);
    waitMode(3'h2);
    // Bypass mux returns to the PLL in sleep, whatever the bypass bit
    chkSt(3'h2, 7'h4D);
    @(posedge sys_clk);
    wakeupPin <= 1'b1;
    waitMode({2'h0, byp});
    chkSt({2'h0, byp}, byp ? 7'h7F : 7'h5F);
    @(posedge sys_clk);
    wakeupPin <= 1'b0;
  endtask
  task t_deep;
    req(1'b1);
    waitMode(3'h3);
    chk("deep", {12'h0, pllOn, coreClkEn, sysClkEn, corePowerOn}, 16'h0001);
    @(posedge sys_clk);
    rtcWakePin <= 1'b1;
    waitMode(3'h1);
    chkSt(3'h1, 7'h7F);
    @(posedge sys_clk);
    rtcWakePin <= 1'b0;
    pll(1'b1, 1'b0, 6'h15);
    waitMode(3'h0);
    req(1'b1);
    waitMode(3'h3);
    @(posedge sys_clk);
    resetWakePin <= 1'b1;
    waitMode(3'h0);
    chkSt(3'h0, 7'h5F);
    @(posedge sys_clk);
    resetWakePin <= 1'b0;
  endtask
  task t_hib;
    int n;
    @(posedge sys_clk);
    regulatorFrequencyIn <= 2'h0;
    coreVoltageIn <= 4'h0;
    vrCtlWr <= 1'b1;
    @(posedge sys_clk);
    vrCtlWr <= 1'b0;
    waitMode(3'h4);
    chk("hib", {11'h0, pllOn, coreClkEn, sysClkEn, corePowerOn, externalWakeOut}, 16'h0);
    @(posedge sys_clk);
    resetWakePin <= 1'b1;
    n = 0;
    while (hwResetReq !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("wake", {12'h0, hwResetReq, modeState}, 16'h0008);
    if (n == 20)
      results();
    @(posedge sys_clk);
    resetWakePin <= 1'b0;
    waitMode(3'h0);
    chkSt(3'h0, 7'h5F);
  endtask
  // Hibernate with a non-zero frequency field; masked RTC wake, then PHY wake
  task t_hib_src;
    int n;
    @(posedge sys_clk);
    regulatorFrequencyIn <= 2'h3;
    coreVoltageIn <= 4'h0;
    vrCtlWr <= 1'b1;
    rtcWakeEnable <= 1'b0;
    phyWakeEnable <= 1'b1;
    @(posedge sys_clk);
    vrCtlWr <= 1'b0;
    rtcWakePin <= 1'b1;
    waitMode(3'h4);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("hib src", {10'h0, modeState, corePowerOn, externalWakeOut, hwResetReq}, 16'h0022);
    @(posedge sys_clk);
    phyWakePin <= 1'b1;
    n = 0;
    while (hwResetReq !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("phy wake", {12'h0, hwResetReq, modeState}, 16'h0008);
    if (n == 20)
      results();
    @(posedge sys_clk);
    phyWakePin <= 1'b0;
    rtcWakePin <= 1'b0;
    waitMode(3'h0);
    chkSt(3'h0, 7'h5F);
  endtask
  task t_periph(input logic [15:0] g);
    @(posedge sys_clk);
    periphGateIn <= g;
    periphGateWr <= 1'b1;
    @(posedge sys_clk);
    periphGateWr <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("gates", periphClkEn, g);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    waitMode(3'h0);
    chkSt(3'h0, 7'h5F);
    chk("mult rst", {10'h0, appliedMultiplier}, 16'h000A);
    t_periph(16'hA5C3);
    t_periph(16'h0000);
    t_active();
    t_sleep(1'b0);
    pll(1'b1, 1'b1, 6'h15);
    waitMode(3'h1);
    t_sleep(1'b1);
    t_deep();
    t_hib();
    t_hib_src();
    results();
  end
endmodule
